// File: pmv_power_ctrl.sv
// power mode controller with voltage scaling and flash handshake
`timescale 1ns/1ps
`default_nettype none
module pmv_power_ctrl
  import pmv_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = PMV_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // current mode from the core sequencer, same clock
  input wire logic [2:0] power_mode_i,
  // flash side
  input wire logic flash_busy_i,
  output logic flash_low_voltage_ack_o,
  output logic flash_sleep_o,
  output logic [2:0] flash_wait_cycles_o,
  // regulators
  output logic main_regulator_on_o,
  output logic low_power_regulator_on_o,
  output logic main_regulator_1v0_o,
  output logic regulator_settled_flag_o,
  // block control
  output logic [1:0] comparator_enable_o,
  output logic config_retain_o,
  output logic wake_by_reset_o,
  // asynchronous wake sources and the combined wake request
  input wire logic [12:0] wake_src_i,
  output logic wake_o
);
  // mode view of the sequencer input
  pmv_mode_t mode;
  assign mode = pmv_mode_t'(power_mode_i);

  // software state
  logic [1:0] main_regulator_voltage_select; // requested level
  logic flash_low_voltage_request;
  logic flash_sleep_request;
  logic [12:0] wake_en;

  // apb decode: access phase with pready high is the commit point
  logic acc, setup, wr;
  logic hit_ctrl1, hit_sts2, hit_facc, hit_wake, mapped;
  assign acc = psel_i && penable_i;
  assign setup = psel_i && !penable_i;
  assign wr = acc && pwrite_i;
  assign hit_ctrl1 = (paddr_i == PMV_OFS_CTRL1);
  assign hit_sts2 = (paddr_i == PMV_OFS_STS2);
  assign hit_facc = (paddr_i == PMV_OFS_FACC);
  assign hit_wake = (paddr_i == PMV_OFS_WAKE);
  assign mapped = hit_ctrl1 || hit_sts2 || hit_facc || hit_wake;
  // no wait states: the read word is captured in the setup phase
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;

  // voltage select write decode; reserved codes are ignored
  logic [1:0] new_code;
  logic code_ok, volt_start;
  assign new_code = pwdata_i[PMV_VSEL_W-1:0];
  assign code_ok = (new_code == PMV_VSEL_1V0) || (new_code == PMV_VSEL_1V1);
  // R06 request new level
  assign volt_start = wr && hit_ctrl1 && code_ok
                      && (new_code != main_regulator_voltage_select);

  // settle timer; the flag is simply its idle state
  logic settle_busy, settle_done;
  pmv_settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(volt_start),
    .busy_o(settle_busy),
    .done_o(settle_done)
  );
  // R16 flag low only while settling
  assign regulator_settled_flag_o = !settle_busy;

  // register writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      main_regulator_voltage_select <= PMV_VSEL_RST;
      flash_low_voltage_request <= 1'b0;
      flash_sleep_request <= 1'b0;
      flash_wait_cycles_o <= PMV_WAIT_RST;
      wake_en <= PMV_WAKE_EN_RST;
    end else if (wr) begin
      if (volt_start)
        main_regulator_voltage_select <= new_code;
      if (hit_facc) begin
        flash_wait_cycles_o <= pwdata_i[PMV_FACC_WAIT_W-1:0];
        flash_low_voltage_request <= pwdata_i[PMV_FACC_LVREQ_BIT];
        flash_sleep_request <= pwdata_i[PMV_FACC_SLEEP_BIT];
      end
      if (hit_wake)
        wake_en <= pwdata_i[PMV_WAKE_N-1:0];
    end
  end

  // R07 level changes when the output has settled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      main_regulator_1v0_o <= 1'b0;
    else if (settle_done)
      main_regulator_1v0_o <= (main_regulator_voltage_select == PMV_VSEL_1V0);
  end

  // flash handshake: follow the request only between accesses
  // so that an in-flight read never sees a voltage step
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flash_low_voltage_ack_o <= 1'b0;
      flash_sleep_o <= 1'b0;
    end else if (!flash_busy_i) begin
      // R03 R08 R17 ack tracks request
      flash_low_voltage_ack_o <= flash_low_voltage_request;
      // R10 sleep while running only
      flash_sleep_o <= flash_sleep_request
                       && (mode == PMV_RUN || mode == PMV_LPRUN);
    end
  end

  // read words, reserved bits zero
  logic [31:0] ctrl1_word, sts2_word, facc_word, wake_word, rd_word;
  assign ctrl1_word = 32'(main_regulator_voltage_select);
  assign sts2_word = (32'(regulator_settled_flag_o) << PMV_STS_SETTLED_BIT)
                   | (32'(flash_low_voltage_ack_o) << PMV_STS_LVACK_BIT)
                   | (32'(power_mode_i) << PMV_STS_MODE_LSB);
  assign facc_word = 32'(flash_wait_cycles_o)
                   | (32'(flash_low_voltage_request) << PMV_FACC_LVREQ_BIT)
                   | (32'(flash_low_voltage_ack_o) << PMV_FACC_LVACK_BIT)
                   | (32'(flash_sleep_request) << PMV_FACC_SLEEP_BIT);
  assign wake_word = 32'(wake_en);
  assign rd_word = hit_ctrl1 ? ctrl1_word :
                   hit_sts2 ? sts2_word :
                   hit_facc ? facc_word :
                   hit_wake ? wake_word : '0;

  // read data register, loaded in the setup phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      prdata_o <= '0;
    else if (setup && !pwrite_i)
      prdata_o <= rd_word;
  end

  // per mode block control
  logic main_on, is_stop, is_standby;
  assign main_on = pmv_main_reg_on(mode);
  assign is_stop = (mode == PMV_STOP);
  assign is_standby = (mode == PMV_STANDBY);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      main_regulator_on_o <= 1'b1;
      low_power_regulator_on_o <= 1'b0;
      comparator_enable_o <= PMV_COMP_EN_RST;
      config_retain_o <= 1'b0;
      wake_by_reset_o <= 1'b0;
    end else begin
      // R15 low power regulator takes over
      main_regulator_on_o <= main_on;
      low_power_regulator_on_o <= !main_on;
      // R13 only first comparator in stop
      comparator_enable_o <= {!is_stop && !is_standby, !is_standby};
      // R11 deep stop retains configuration
      config_retain_o <= is_stop;
      // standby wake restarts from reset, stop resumes in place
      wake_by_reset_o <= is_standby;
    end
  end

  // wake inputs: three stages, a change counts when two agree
  logic [12:0] wk_s1, wk_s2, wk_s3, wk_stable;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wk_s1 <= '0;
      wk_s2 <= '0;
      wk_s3 <= '0;
      wk_stable <= '0;
    end else begin
      wk_s1 <= wake_src_i;
      wk_s2 <= wk_s1;
      wk_s3 <= wk_s2;
      wk_stable <= (wk_s2 & wk_s3) | (wk_stable & (wk_s2 | wk_s3));
    end
  end

  // R12 R14 wake gated by mode mask
  logic [12:0] wake_hit;
  assign wake_hit = wk_stable & wake_en & pmv_wake_allow(mode);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      wake_o <= 1'b0;
    else
      wake_o <= |wake_hit;
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_volt_req;
    volt_start;
  endsequence
  sequence s_settling;
    !regulator_settled_flag_o [*8];
  endsequence
  settle_drop_a: assert property (s_volt_req |=> s_settling) // R06
    else $error("settle flag did not drop after voltage write");
  settle_idle_a: assert property ( // R16
    $fell(regulator_settled_flag_o) |-> $past(volt_start))
    else $error("settle flag fell without a voltage write");
  level_follow_a: assert property ( // R07
    $rose(regulator_settled_flag_o) |=> main_regulator_1v0_o
      == (main_regulator_voltage_select == PMV_VSEL_1V0))
    else $error("regulator level wrong after settling");
  lv_ack_up_a: assert property ( // R03
    flash_low_voltage_request && !flash_busy_i |=> flash_low_voltage_ack_o)
    else $error("flash low voltage ack missing");
  lv_ack_down_a: assert property ( // R08
    !flash_low_voltage_request && !flash_busy_i |=> !flash_low_voltage_ack_o)
    else $error("flash low voltage ack not cleared");
  ack_busy_hold_a: assert property ( // R17
    flash_busy_i |=> $stable(flash_low_voltage_ack_o))
    else $error("flash ack changed during an access");
  flash_sleep_a: assert property ( // R10
    mode == PMV_RUN && flash_sleep_request && !flash_busy_i |=> flash_sleep_o)
    else $error("flash did not enter sleep");
  stop_retain_a: assert property ( // R11
    is_stop |=> config_retain_o && comparator_enable_o == 2'h1)
    else $error("deep stop retention or comparator wrong");
  reg_swap_a: assert property ( // R15
    !main_on |=> !main_regulator_on_o && low_power_regulator_on_o)
    else $error("main regulator on in a low power mode");
  standby_gpio_a: assert property ( // R14
    is_standby && (wk_stable & wake_en & PMV_WAKE_STANDBY) == '0
      |=> !wake_o)
    else $error("non wake-pin source woke standby");
endmodule
`default_nettype wire

// File: pmv_pkg.sv
// constants, types and helpers shared by the power mode controller
// Notes on behaviour
// R01: software keeps clock low before requesting 1.0V
// R02: software sets two flash wait cycles first
// R03: flash acknowledges low voltage once truly entered
// R04: software sets waits above 30ns afterwards
// R05: software sets sram normal before voltage change
// R06: code 0x2 requests 1.0V, flag drops
// R07: code 0x3 returns to 1.1V, flag cycles
// R08: clearing request drops acknowledge after exit
// R09: software raises clock, then sets waits
// R10: sleep request parks idle flash, clear restores
// R11: deep stop keeps configuration, resumes in place
// R12: per mode block availability and wake sources
// R13: only first comparator works in deep stop
// R14: standby gpio wake limited to three pins
// R15: main regulator off in low power modes
// R16: settle flag low only during transition
// R17: acknowledge changes only between flash accesses
package pmv_pkg;
  // clock and regulator settle time
  localparam int unsigned PMV_CLK_HZ = 100_000_000;
  localparam int unsigned PMV_SETTLE_US = 100;
  localparam int unsigned PMV_SETTLE_CYC =
    (PMV_CLK_HZ / 1_000_000) * PMV_SETTLE_US;
  localparam int unsigned PMV_SETTLE_CW = 16;
  // register byte offsets
  localparam logic [11:0] PMV_OFS_CTRL1 = 12'h000;
  localparam logic [11:0] PMV_OFS_STS2 = 12'h004;
  localparam logic [11:0] PMV_OFS_FACC = 12'h008;
  localparam logic [11:0] PMV_OFS_WAKE = 12'h00c;
  // power_control_one fields
  localparam int unsigned PMV_VSEL_W = 2;
  localparam logic [1:0] PMV_VSEL_1V0 = 2'h2;
  localparam logic [1:0] PMV_VSEL_1V1 = 2'h3;
  localparam logic [1:0] PMV_VSEL_RST = 2'h3;
  // both comparator groups usable out of reset
  localparam logic [1:0] PMV_COMP_EN_RST = 2'h3;
  // power_status_two fields
  localparam int unsigned PMV_STS_SETTLED_BIT = 0;
  localparam int unsigned PMV_STS_LVACK_BIT = 1;
  localparam int unsigned PMV_STS_MODE_LSB = 4;
  // flash_access_control fields
  localparam int unsigned PMV_FACC_WAIT_W = 3;
  localparam int unsigned PMV_FACC_LVREQ_BIT = 8;
  localparam int unsigned PMV_FACC_LVACK_BIT = 9;
  localparam int unsigned PMV_FACC_SLEEP_BIT = 10;
  localparam logic [2:0] PMV_WAIT_RST = 3'h0;
  // wake sources: rtc, independent watchdog, pvd, low power timer,
  // low power serial port, first comparator, other comparators, lcd,
  // other gpio, tamper, three wake pins
  localparam int unsigned PMV_WAKE_N = 13;
  localparam logic [12:0] PMV_WAKE_ALL = 13'h1fff;
  // deep stop: the wake pins are gpio too, so they stay armed there
  localparam logic [12:0] PMV_WAKE_STOP = 13'h1dbf;
  localparam logic [12:0] PMV_WAKE_STANDBY = 13'h1e03;
  localparam logic [12:0] PMV_WAKE_EN_RST = 13'h1fff;

  // power modes as reported by the core sequencer
  typedef enum logic [2:0] {
    PMV_RUN, PMV_SLEEP, PMV_LPRUN, PMV_LPSLEEP, PMV_STOP, PMV_STANDBY
  } pmv_mode_t;

  // main regulator only serves the full speed modes
  function automatic logic pmv_main_reg_on(input pmv_mode_t m);
    unique case (m)
      PMV_RUN, PMV_SLEEP: pmv_main_reg_on = 1'b1;
      PMV_LPRUN, PMV_LPSLEEP, PMV_STOP, PMV_STANDBY: pmv_main_reg_on = 1'b0;
      default: pmv_main_reg_on = 1'b0;
    endcase
  endfunction

  // which wake sources may act in a mode
  function automatic logic [12:0] pmv_wake_allow(input pmv_mode_t m);
    unique case (m)
      PMV_STOP: pmv_wake_allow = PMV_WAKE_STOP;
      PMV_STANDBY: pmv_wake_allow = PMV_WAKE_STANDBY;
      PMV_RUN, PMV_SLEEP, PMV_LPRUN, PMV_LPSLEEP:
        pmv_wake_allow = PMV_WAKE_ALL;
      default: pmv_wake_allow = '0;
    endcase
  endfunction
endpackage

// File: pmv_settle_timer.sv
// regulator settle timer: busy for a fixed number of cycles per start
`timescale 1ns/1ps
`default_nettype none
module pmv_settle_timer
  import pmv_pkg::*;
#(
  parameter int unsigned CYCLES = PMV_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  // cycles spent so far in the current transition
  logic [PMV_SETTLE_CW-1:0] count;
  // terminal count reached
  logic last;

  assign last = (count == PMV_SETTLE_CW'(CYCLES - 1));

  // a new start restarts the wait, so the flag never rises early
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        busy_o <= 1'b1;
        count <= '0;
      end else if (busy_o && last) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end else if (busy_o) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: pmv_power_ctrl_test.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module pmv_power_ctrl_test
  import pmv_pkg::*;
;
  // short settle count keeps the run brief
  localparam int unsigned SETTLE = 16;
  logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, flash_busy_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd_data;
  logic pready_o, pslverr_o, rd_err;
  logic [2:0] power_mode_i, flash_wait_cycles_o;
  logic flash_low_voltage_ack_o, flash_sleep_o, main_regulator_on_o;
  logic low_power_regulator_on_o, main_regulator_1v0_o;
  logic regulator_settled_flag_o, config_retain_o, wake_by_reset_o, wake_o;
  logic [1:0] comparator_enable_o;
  logic [12:0] wake_src_i, mask;
  int error_cnt, n_checks, cycles;

  pmv_power_ctrl #(.SETTLE_CYCLES(SETTLE)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .power_mode_i(power_mode_i),
    .flash_busy_i(flash_busy_i),
    .flash_low_voltage_ack_o(flash_low_voltage_ack_o),
    .flash_sleep_o(flash_sleep_o),
    .flash_wait_cycles_o(flash_wait_cycles_o),
    .main_regulator_on_o(main_regulator_on_o),
    .low_power_regulator_on_o(low_power_regulator_on_o),
    .main_regulator_1v0_o(main_regulator_1v0_o),
    .regulator_settled_flag_o(regulator_settled_flag_o),
    .comparator_enable_o(comparator_enable_o),
    .config_retain_o(config_retain_o), .wake_by_reset_o(wake_by_reset_o),
    .wake_src_i(wake_src_i), .wake_o(wake_o)
  );

  // free-running system clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // hang guard: the whole sequence needs about fifteen hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // only pready high or the bench timeout may end this wait
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd_data = prdata_o;
    rd_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic exp_err);
    apb(1'b0, a, 32'h0);
    chk("prdata", rd_data, exp);
    chk("pslverr", 32'(rd_err), 32'(exp_err));
  endtask

  // voltage request, then measure how long the settle flag stays low
  task automatic volt(input logic [1:0] code, input logic exp_1v0);
    int n;
    apb(1'b1, PMV_OFS_CTRL1, {30'h0, code});
    #1;
    chk("settled_low", 32'(regulator_settled_flag_o), 32'h0);
    n = 0;
    while (regulator_settled_flag_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("settle_cycles", 32'(n), 32'(SETTLE));
    // the level output follows the done pulse, one edge after the flag
    @(posedge clk_i);
    #1;
    chk("main_1v0", 32'(main_regulator_1v0_o), 32'(exp_1v0));
  endtask

  // wait a few edges after a flash request and look at the flags
  task automatic flash_req(input logic [31:0] d, input logic ack,
                           input logic slp);
    apb(1'b1, PMV_OFS_FACC, d);
    repeat (2) @(posedge clk_i);
    #1;
    chk("lv_ack", 32'(flash_low_voltage_ack_o), 32'(ack));
    chk("flash_sleep", 32'(flash_sleep_o), 32'(slp));
  endtask

  initial begin
    {psel_i, penable_i, pwrite_i, flash_busy_i} = 4'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    power_mode_i = 3'h0;
    wake_src_i = 13'h0;
    rst_n_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("settled_rst", 32'(regulator_settled_flag_o), 32'h1);
    chk("main_on_rst", 32'(main_regulator_on_o), 32'h1);
    chk("comp_rst", 32'(comparator_enable_o), 32'h3);
    rd(PMV_OFS_CTRL1, 32'h3, 1'b0);
    rd(PMV_OFS_WAKE, 32'h1fff, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    // flash to two wait cycles, then request low voltage while busy
    apb(1'b1, PMV_OFS_FACC, 32'h2);
    flash_busy_i <= 1'b1;
    #1;
    chk("wait", 32'(flash_wait_cycles_o), 32'h2);
    flash_req(32'h102, 1'b0, 1'b0);
    @(posedge clk_i);
    flash_busy_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("lv_ack_up", 32'(flash_low_voltage_ack_o), 32'h1);
    rd(PMV_OFS_FACC, 32'h302, 1'b0);
    // clock and sram taken as ready
    volt(PMV_VSEL_1V0, 1'b1);
    apb(1'b1, PMV_OFS_CTRL1, 32'h2);
    #1;
    chk("same_code", 32'(regulator_settled_flag_o), 32'h1);
    apb(1'b1, PMV_OFS_CTRL1, 32'h1);
    #1;
    chk("bad_code", 32'(regulator_settled_flag_o), 32'h1);
    rd(PMV_OFS_STS2, 32'h3, 1'b0);
    volt(PMV_VSEL_1V1, 1'b0);
    flash_req(32'h2, 1'b0, 1'b0);
    flash_req(32'h402, 1'b0, 1'b1);
    // slow clock allows zero wait cycles
    flash_req(32'h0, 1'b0, 1'b0);
    chk("wait_low", 32'(flash_wait_cycles_o), 32'h0);
    // walk every mode and every wake source
    for (int m = 0; m < 6; m++) begin
      @(posedge clk_i);
      power_mode_i <= 3'(m);
      repeat (2) @(posedge clk_i);
      #1;
      mask = (m == 4) ? PMV_WAKE_STOP
           : (m == 5) ? PMV_WAKE_STANDBY : PMV_WAKE_ALL;
      chk("main_on", 32'(main_regulator_on_o), 32'(m < 2));
      chk("lp_on", 32'(low_power_regulator_on_o), 32'(m >= 2));
      chk("retain", 32'(config_retain_o), 32'(m == 4));
      chk("by_reset", 32'(wake_by_reset_o), 32'(m == 5));
      chk("comp", 32'(comparator_enable_o),
          (m == 4) ? 32'h1 : (m == 5) ? 32'h0 : 32'h3);
      for (int s = 0; s < PMV_WAKE_N; s++) begin
        @(posedge clk_i);
        wake_src_i <= 13'h1 << s;
        repeat (8) @(posedge clk_i);
        #1;
        chk("wake", 32'(wake_o), 32'(mask[s]));
        @(posedge clk_i);
        wake_src_i <= 13'h0;
        repeat (8) @(posedge clk_i);
      end
    end
    // masked sources in run mode stay silent
    @(posedge clk_i);
    power_mode_i <= 3'h0;
    apb(1'b1, PMV_OFS_WAKE, 32'h0);
    wake_src_i <= 13'h1fff;
    repeat (8) @(posedge clk_i);
    #1;
    chk("wake_masked", 32'(wake_o), 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
